// ==== trla_pkg.sv ====
// Package for the thermal reading and limit alert block.
// Assumes a byte-wide register port driven by the host-side serial front end.
package trla_pkg;
    // Register offsets
    localparam logic [7:0] OFF_READ_HI  = 8'h0A;
    localparam logic [7:0] OFF_READ_LO  = 8'h0B;
    localparam logic [7:0] OFF_UP_LIM   = 8'h0C;
    localparam logic [7:0] OFF_LO_LIM   = 8'h0D;
    localparam logic [7:0] OFF_DEADBAND = 8'h0E;
    // Reset values
    localparam logic [6:0] RST_UP_LIM   = 7'h55;
    localparam logic [7:0] RST_LO_LIM   = 8'h00;
    localparam logic [4:0] RST_DEADBAND = 5'h05;
    localparam logic [10:0] RST_TEMP    = 11'h000;
    // Field layout
    localparam int TEMP_W    = 11;
    localparam int FRAC_W    = 3;
    localparam int LO_PAD_W  = 5;
    // Register access bundle
    typedef struct packed {
        logic       wr;   // Write strobe
        logic       rd;   // Read strobe
        logic [7:0] addr; // Register offset
        logic [7:0] wdata;// Write data
    } trla_req_t;
    // Check phase: rising-check pending or falling-check pending
    typedef enum logic [1:0] {
        TRLA_WAIT_RISE = 2'b01,
        TRLA_WAIT_FALL = 2'b10
    } trla_phase_t;
endpackage

// ==== trla_top.sv ====
// Function
// - High reading holds integer temperature bits, reset zero
// - Low reading holds fraction in bits 7:5
// - Reading is 11-bit two's complement, eighth degree
// - Upper limit 7-bit unsigned, reset 85
// - Rising above upper limit sets event flag
// - Then falling below limit minus deadband sets flag
// - Sleep exit or upper write rearms rising check
// - Lower limit 8-bit signed, reset zero
// - Falling below lower limit sets event flag
// - Then rising above lower limit sets flag
// - Sleep exit or lower write rearms falling check
// - Deadband 5-bit unsigned, reset five
// - Unmasked event flag drives alert low
// - Mask blocks alert only, flag still set
//
// Thermal readout, limit compare and alert generation.
// Assumes the sensor delivers a sample with a one-cycle valid strobe,
// and that status clear, mask bit and sleep exit come from the system.
`timescale 1ns/1ns
module trla_top (
    input  wire logic                clk,           // 100 MHz clock
    input  wire logic                rst,           // Async reset, high
    input  wire trla_pkg::trla_req_t reg_req,       // Register access
    output logic [7:0]               reg_rdata,     // Read data, registered
    input  wire logic [10:0]         sample_temp,   // Converted temperature
    input  wire logic                sample_valid,  // New sample strobe
    input  wire logic                sleep_exit,    // Leaving sleep pulse
    input  wire logic                thermal_event_mask, // Mask bit from mask register
    input  wire logic                flag_clear,    // Host clears event flag
    output logic                     thermal_event_flag, // Sticky event flag
    output logic                     alert_n        // Alert pin, active low
);
    // Register state
    logic [10:0] temp_reg, temp_next;          // Combined reading
    logic [6:0]  up_reg, up_next;              // Upper limit
    logic [7:0]  lo_reg, lo_next;              // Lower limit
    logic [4:0]  db_reg, db_next;              // Deadband
    logic [7:0]  rdata_reg, rdata_next;        // Read data
    logic        flag_reg, flag_next;          // Event flag
    trla_pkg::trla_phase_t hi_reg, hi_next;    // Upper check phase
    trla_pkg::trla_phase_t lo_ph_reg, lo_ph_next; // Lower check phase
    logic        up_ev, lo_ev;                 // Crossing events

    // Sign-extend a whole-degree value to reading scale (x8)
    function automatic logic signed [13:0] to_scale(input logic signed [9:0] deg);
        to_scale = {deg[9], deg, 3'b000};                             // Keep sign across the x8 shift
    endfunction

    logic signed [13:0] t_s, up_s, fall_s, lo_s; // Compare operands
    always_comb begin
        t_s    = 14'(signed'(temp_reg));
        up_s   = to_scale({3'b000, up_reg});
        fall_s = to_scale(10'(signed'({3'b000, up_reg})) - 10'(signed'({5'b00000, db_reg})));
        lo_s   = to_scale(10'(signed'(lo_reg)));
    end

    // Next-state for registers, phases and flag
    always_comb begin
        temp_next  = temp_reg;
        up_next    = up_reg;
        lo_next    = lo_reg;
        db_next    = db_reg;
        hi_next    = hi_reg;
        lo_ph_next = lo_ph_reg;
        up_ev      = 1'b0;
        lo_ev      = 1'b0;
        if (sample_valid) begin
            temp_next = sample_temp;
        end
        // Upper threshold check
        unique case (hi_reg)
            trla_pkg::TRLA_WAIT_RISE: begin
                if (t_s > up_s) begin
                    up_ev   = 1'b1;
                    hi_next = trla_pkg::TRLA_WAIT_FALL;
                end
            end
            trla_pkg::TRLA_WAIT_FALL: begin
                if (t_s < fall_s) begin
                    up_ev   = 1'b1;
                    hi_next = trla_pkg::TRLA_WAIT_RISE;
                end
            end
        endcase
        // Lower threshold check, no deadband
        unique case (lo_ph_reg)
            trla_pkg::TRLA_WAIT_FALL: begin
                if (t_s < lo_s) begin
                    lo_ev      = 1'b1;
                    lo_ph_next = trla_pkg::TRLA_WAIT_RISE;
                end
            end
            trla_pkg::TRLA_WAIT_RISE: begin
                if (t_s > lo_s) begin
                    lo_ev      = 1'b1;
                    lo_ph_next = trla_pkg::TRLA_WAIT_FALL;
                end
            end
        endcase
        // Register writes
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                trla_pkg::OFF_UP_LIM: begin
                    up_next = reg_req.wdata[6:0];
                    hi_next = trla_pkg::TRLA_WAIT_RISE;
                end
                trla_pkg::OFF_LO_LIM: begin
                    lo_next    = reg_req.wdata;
                    lo_ph_next = trla_pkg::TRLA_WAIT_FALL;
                end
                trla_pkg::OFF_DEADBAND: begin
                    db_next = reg_req.wdata[4:0];
                end
                default: begin
                end
            endcase
        end
        // Sleep exit rearms both checks
        if (sleep_exit) begin
            hi_next    = trla_pkg::TRLA_WAIT_RISE;
            lo_ph_next = trla_pkg::TRLA_WAIT_FALL;
        end
        // Sticky flag; a new event wins over clear
        flag_next = (flag_reg && !flag_clear) || up_ev || lo_ev;
    end

    // Read data mux
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                trla_pkg::OFF_READ_HI:  rdata_next = temp_reg[10:3];
                trla_pkg::OFF_READ_LO:  rdata_next = {temp_reg[2:0], 5'h00};
                trla_pkg::OFF_UP_LIM:   rdata_next = {1'b0, up_reg};
                trla_pkg::OFF_LO_LIM:   rdata_next = lo_reg;
                trla_pkg::OFF_DEADBAND: rdata_next = {3'b000, db_reg};
                default:                rdata_next = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_reg  <= trla_pkg::RST_TEMP;
            up_reg    <= trla_pkg::RST_UP_LIM;
            lo_reg    <= trla_pkg::RST_LO_LIM;
            db_reg    <= trla_pkg::RST_DEADBAND;
            rdata_reg <= 8'h00;
            flag_reg  <= 1'b0;
            hi_reg    <= trla_pkg::TRLA_WAIT_RISE;
            lo_ph_reg <= trla_pkg::TRLA_WAIT_FALL;
        end else begin
            temp_reg  <= temp_next;
            up_reg    <= up_next;
            lo_reg    <= lo_next;
            db_reg    <= db_next;
            rdata_reg <= rdata_next;
            flag_reg  <= flag_next;
            hi_reg    <= hi_next;
            lo_ph_reg <= lo_ph_next;
        end
    end

    // Outputs
    assign reg_rdata          = rdata_reg;
    assign thermal_event_flag = flag_reg;
    assign alert_n            = !(flag_reg && !thermal_event_mask);

    // Assertions
    sequence s_up_rise;
        hi_reg == trla_pkg::TRLA_WAIT_RISE && t_s > up_s && !reg_req.wr && !sleep_exit;
    endsequence
    property p_up_rise;
        @(posedge clk) disable iff (rst) s_up_rise |=> flag_reg && hi_reg == trla_pkg::TRLA_WAIT_FALL;
    endproperty
    a_up_rise: assert property (p_up_rise) else $error("upper rise missed");
    property p_up_fall;
        @(posedge clk) disable iff (rst)
            hi_reg == trla_pkg::TRLA_WAIT_FALL && t_s < fall_s |=> flag_reg;
    endproperty
    a_up_fall: assert property (p_up_fall) else $error("upper fall missed");
    property p_up_rearm;
        @(posedge clk) disable iff (rst)
            (reg_req.wr && reg_req.addr == trla_pkg::OFF_UP_LIM) || sleep_exit |=> hi_reg == trla_pkg::TRLA_WAIT_RISE;
    endproperty
    a_up_rearm: assert property (p_up_rearm) else $error("upper not rearmed");
    property p_lo_fall;
        @(posedge clk) disable iff (rst)
            lo_ph_reg == trla_pkg::TRLA_WAIT_FALL && t_s < lo_s |=> flag_reg;
    endproperty
    a_lo_fall: assert property (p_lo_fall) else $error("lower fall missed");
    property p_lo_rise;
        @(posedge clk) disable iff (rst)
            lo_ph_reg == trla_pkg::TRLA_WAIT_RISE && t_s > lo_s |=> flag_reg;
    endproperty
    a_lo_rise: assert property (p_lo_rise) else $error("lower rise missed");
    property p_lo_rearm;
        @(posedge clk) disable iff (rst)
            (reg_req.wr && reg_req.addr == trla_pkg::OFF_LO_LIM) || sleep_exit |=> lo_ph_reg == trla_pkg::TRLA_WAIT_FALL;
    endproperty
    a_lo_rearm: assert property (p_lo_rearm) else $error("lower not rearmed");
    property p_alert;
        @(posedge clk) disable iff (rst)
            (up_ev || lo_ev) && !thermal_event_mask ##1 !thermal_event_mask |-> !alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert mismatch");
    property p_hold;
        @(posedge clk) disable iff (rst) flag_reg && !flag_clear |=> flag_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_read_lo;
        @(posedge clk) disable iff (rst)
            reg_req.rd && reg_req.addr == trla_pkg::OFF_READ_LO |=> reg_rdata[4:0] == 5'h00 && reg_rdata[7:5] == $past(temp_reg[2:0]);
    endproperty
    a_read_lo: assert property (p_read_lo) else $error("low reading wrong");
    property p_read_hi;
        @(posedge clk) disable iff (rst)
            reg_req.rd && reg_req.addr == trla_pkg::OFF_READ_HI |=> reg_rdata == $past(temp_reg[10:3]);
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("high reading wrong");
endmodule // trla_top

// ==== trla_host.sv ====
// Host controller model: register access and flag clear.
// Assumes the block takes requests on the rising clock edge.
`timescale 1ns/1ns
module trla_host (
    input  wire logic           clk,       // Block clock
    input  wire logic [7:0]     rdata,     // Read data
    output trla_pkg::trla_req_t req,       // Register access
    output logic                flag_clear // Flag clear pulse
);
    // Idle bus at time zero
    initial begin
        req = '0;
        flag_clear = 1'h0;
    end
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk) req <= '0;
    endtask
    // Read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask
    // Clear after each handled alert
    task automatic clr();
        @(posedge clk) flag_clear <= 1'h1;
        @(posedge clk) flag_clear <= 1'h0;
    endtask
endmodule // trla_host

// ==== trla_tb.sv ====
// Testbench for the thermal reading and limit alert block.
// Assumes the host model above owns the register port.
`timescale 1ns/1ns
module testbench;
    logic                clk = 1'h0;  // 100 MHz clock
    logic                rst = 1'h1;  // Reset, high
    logic [10:0]         st  = 11'h000; // Sample value
    logic                sv  = 1'h0;  // Sample strobe
    logic                se  = 1'h0;  // Sleep exit
    logic                msk = 1'h0;  // Event mask
    logic [7:0]          rdata;       // Read data
    trla_pkg::trla_req_t req;         // Register access
    logic                fc;          // Flag clear
    logic                flg;         // Event flag
    logic                aln;         // Alert pin
    int                  n_mismatch = 0; // Mismatch count
    int                  checks = 0;  // Comparison count
    // Clock
    always #5 clk = ~clk;
    // Device and host
    trla_top u_trla_top (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
        .sample_temp(st), .sample_valid(sv), .sleep_exit(se), .thermal_event_mask(msk),
        .flag_clear(fc), .thermal_event_flag(flg), .alert_n(aln));
    trla_host u_trla_host (.clk(clk), .rdata(rdata), .req(req), .flag_clear(fc));
    // Value compare
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Register read compare
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_trla_host.rd(a, d);
        cmp(d, e);
    endtask
    // Sample, then flag and alert two cycles on
    task automatic ev(input logic [10:0] t, input logic e);
        @(posedge clk) st <= t;
        sv <= 1'h1;
        @(posedge clk) sv <= 1'h0;
        @(posedge clk) #1 cmp(flg, e);
        cmp(aln, !e | msk);
        if (e) begin
            repeat (3) @(posedge clk);
            #1 cmp(flg, 1'h1);
            u_trla_host.clr();
            #1 cmp(flg, 1'h0);
        end
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rc(8'h0A, 8'h00);
        rc(8'h0B, 8'h00);
        rc(8'h0C, 8'h55);
        rc(8'h0D, 8'h00);
        rc(8'h0E, 8'h05);
        rc(8'h0F, 8'h00);
        u_trla_host.wr(8'h0C, 8'hFF);
        u_trla_host.wr(8'h0E, 8'hFF);
        u_trla_host.wr(8'h0D, 8'h80);
        u_trla_host.wr(8'h0A, 8'h33);
        rc(8'h0C, 8'h7F);
        rc(8'h0E, 8'h1F);
        rc(8'h0D, 8'h80);
        rc(8'h0A, 8'h00);
        $display("test registers done");
        ev(11'h7FF, 1'h0); rc(8'h0A, 8'hFF); rc(8'h0B, 8'hE0);
        ev(11'h00F, 1'h0); rc(8'h0A, 8'h01); rc(8'h0B, 8'hE0);
        ev(11'h600, 1'h0); rc(8'h0A, 8'hC0); rc(8'h0B, 8'h00);
        $display("test readings done");
        u_trla_host.wr(8'h0C, 8'h14);
        u_trla_host.wr(8'h0E, 8'h05);
        ev(11'h0A0, 1'h0);
        ev(11'h0A1, 1'h1);
        u_trla_host.wr(8'h0C, 8'h1E);
        ev(11'h064, 1'h0);
        u_trla_host.wr(8'h0C, 8'h14);
        ev(11'h0A1, 1'h1);
        ev(11'h078, 1'h0);
        ev(11'h077, 1'h1);
        @(posedge clk) msk <= 1'h1;
        ev(11'h0A1, 1'h1);
        @(posedge clk) msk <= 1'h0;
        $display("test upper limit done");
        u_trla_host.wr(8'h0C, 8'h7F);
        u_trla_host.wr(8'h0D, 8'hFE);
        ev(11'h7EF, 1'h1);
        ev(11'h7F0, 1'h0);
        @(posedge clk) se <= 1'h1;
        @(posedge clk) se <= 1'h0;
        ev(11'h7F1, 1'h0);
        ev(11'h7EF, 1'h1);
        ev(11'h7F0, 1'h0);
        ev(11'h7F1, 1'h1);
        $display("test lower limit done");
        conclude();
    end
endmodule // testbench
